// ### design/h2c_byp_axil.sv
`timescale 1ns/1ps
module h2c_byp_axil (
    // Clock and reset
    input wire logic aclk,
    input wire logic aresetn,
    // AXI4-Lite slave
    input wire logic [7:0] s_axil_awaddr,
    input wire logic s_axil_awvalid,
    output logic s_axil_awready,
    input wire logic [31:0] s_axil_wdata,
    input wire logic [3:0] s_axil_wstrb,
    input wire logic s_axil_wvalid,
    output logic s_axil_wready,
    output logic [1:0] s_axil_bresp,
    output logic s_axil_bvalid,
    input wire logic s_axil_bready,
    input wire logic [7:0] s_axil_araddr,
    input wire logic s_axil_arvalid,
    output logic s_axil_arready,
    output logic [31:0] s_axil_rdata,
    output logic [1:0] s_axil_rresp,
    output logic s_axil_rvalid,
    input wire logic s_axil_rready,
    // Register access towards the engine
    output logic wr_en,
    output logic [7:0] wr_addr,
    output logic [31:0] wr_data,
    output logic [3:0] wr_strb,
    output logic [7:0] rd_addr,
    input wire logic [31:0] rd_data,
    input wire logic rd_hit,
    input wire logic wr_hit
);
    logic aw_held;
    logic w_held;
    logic [7:0] aw_addr;

    // Each channel is taken on its own; write fires once both are in
    assign s_axil_awready = !aw_held && !s_axil_bvalid;
    assign s_axil_wready = !w_held && !s_axil_bvalid;
    assign wr_en = aw_held && w_held && !s_axil_bvalid;
    assign wr_addr = aw_addr;
    assign rd_addr = s_axil_araddr;
    assign s_axil_arready = !s_axil_rvalid;

    // Write address and data capture
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            aw_held <= 1'b0;
            w_held <= 1'b0;
            aw_addr <= 8'h00;
            wr_data <= 32'h0000_0000;
            wr_strb <= 4'h0;
        end else if (wr_en) begin
            aw_held <= 1'b0;
            w_held <= 1'b0;
        end else begin
            if (s_axil_awvalid && s_axil_awready) begin
                aw_held <= 1'b1;
                aw_addr <= s_axil_awaddr;
            end
            if (s_axil_wvalid && s_axil_wready) begin
                w_held <= 1'b1;
                wr_data <= s_axil_wdata;
                wr_strb <= s_axil_wstrb;
            end
        end
    end

    // Write response; unmapped offsets answer SLVERR
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            s_axil_bvalid <= 1'b0;
            s_axil_bresp <= h2c_byp_pkg::RESP_OKAY;
        end else if (wr_en) begin
            s_axil_bvalid <= 1'b1;
            s_axil_bresp <= wr_hit ? h2c_byp_pkg::RESP_OKAY : h2c_byp_pkg::RESP_SLVERR;
        end else if (s_axil_bready) begin
            s_axil_bvalid <= 1'b0;
        end
    end

    // Read data registered one cycle after the address
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            s_axil_rvalid <= 1'b0;
            s_axil_rdata <= 32'h0000_0000;
            s_axil_rresp <= h2c_byp_pkg::RESP_OKAY;
        end else if (s_axil_arvalid && s_axil_arready) begin
            s_axil_rvalid <= 1'b1;
            s_axil_rdata <= rd_hit ? rd_data : 32'h0000_0000;
            s_axil_rresp <= rd_hit ? h2c_byp_pkg::RESP_OKAY : h2c_byp_pkg::RESP_SLVERR;
        end else if (s_axil_rready) begin
            s_axil_rvalid <= 1'b0;
        end
    end
endmodule

// ### design/h2c_byp_fifo.sv
`timescale 1ns/1ps
module h2c_byp_fifo #(
    parameter int WIDTH = 33,
    parameter int DEPTH = 32
) (
    // Clock and reset
    input wire logic aclk,
    input wire logic aresetn,
    // Fill side
    input wire logic in_valid,
    output logic in_ready,
    input wire logic [WIDTH-1:0] in_data,
    // Drain side
    output logic out_valid,
    input wire logic out_ready,
    output logic [WIDTH-1:0] out_data
);
    localparam int AW = $clog2(DEPTH);
    logic [WIDTH-1:0] mem [DEPTH];
    logic [AW-1:0] wr_ptr;
    logic [AW-1:0] rd_ptr;
    logic [AW:0] count;
    logic push;
    logic pop;

    // Honest flags straight from the occupancy
    assign in_ready = (count != (AW+1)'(DEPTH));
    assign out_valid = (count != '0);
    assign push = in_valid && in_ready;
    assign pop = out_valid && out_ready;
    assign out_data = mem[rd_ptr];

    // Storage, no reset needed on data
    always_ff @(posedge aclk) begin
        if (push) begin
            mem[wr_ptr] <= in_data;
        end
    end

    // Pointers and occupancy
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            wr_ptr <= '0;
            rd_ptr <= '0;
            count <= '0;
        end else begin
            if (push) begin
                wr_ptr <= (wr_ptr == AW'(DEPTH-1)) ? '0 : wr_ptr + 1'b1;
            end
            if (pop) begin
                rd_ptr <= (rd_ptr == AW'(DEPTH-1)) ? '0 : rd_ptr + 1'b1;
            end
            count <= count + (AW+1)'(push) - (AW+1)'(pop);
        end
    end
endmodule

// ### design/h2c_byp_pkg.sv
// Contract
// - Status request writes a status descriptor after the last byte is fetched.
// - Interrupt only when the queue has interrupts enabled and armed.
// - Errored final descriptor without status request leaves pending set, queue hangs.
// - Marker request passes the pipeline, then a marker response is emitted.
// - One valid pulse per descriptor; engine shows readiness on ready.
// - No-transfer: no reads, no data, address and length ignored; first and last set.
// - No-transfer without marker or status request is a silent no-operation.
package h2c_byp_pkg;
    localparam int ADDR_W = 64;
    localparam int LEN_W = 16;
    localparam int QID_W = 11;
    localparam int NUM_QUEUES = 2048;
    localparam int DATA_W = 32;
    localparam int FIFO_DEPTH = 32;
    localparam int BYTES_PER_BEAT = 4;
    // AXI4-Lite register offsets (byte addresses)
    localparam logic [7:0] REG_CONTROL = 8'h00;
    localparam logic [7:0] REG_QUEUE_SEL = 8'h04;
    localparam logic [7:0] REG_QUEUE_CTX = 8'h08;
    localparam logic [7:0] REG_STATUS = 8'h0c;
    localparam logic [7:0] REG_STATUS_COUNT = 8'h10;
    localparam logic [7:0] REG_MARKER_COUNT = 8'h14;
    // Queue context bit positions
    localparam int CTX_IRQ_ENABLE = 0;
    localparam int CTX_IRQ_ARMED = 1;
    localparam int CTX_PENDING = 2;
    localparam int CTX_ERROR = 3;
    localparam logic [1:0] RESP_OKAY = 2'h0;
    localparam logic [1:0] RESP_SLVERR = 2'h2;
    typedef struct packed {
        logic [ADDR_W-1:0] src_address;
        logic [LEN_W-1:0] byte_count;
        logic packet_first;
        logic packet_last;
        logic status_irq_request;
        logic marker_request;
        logic no_transfer;
        logic error_flag;
        logic [QID_W-1:0] queue_number;
    } desc_t;
    typedef struct packed {
        logic [DATA_W-1:0] data;
        logic last;
    } beat_t;
    typedef struct packed {
        logic irq_enable;
        logic irq_armed;
        logic pending;
        logic error;
    } queue_ctx_t;
endpackage

// ### design/h2c_st_desc_bypass_in.sv
`timescale 1ns/1ps
module h2c_st_desc_bypass_in (
    // Clock and reset
    input wire logic aclk,
    input wire logic aresetn,
    // Descriptor bypass input
    input wire h2c_byp_pkg::desc_t desc_in,
    input wire logic desc_valid,
    output logic desc_ready,
    // Host read request (one request per descriptor that moves data; none for no-transfer or errored ones)
    output logic host_rd_valid,
    input wire logic host_rd_ready,
    output logic [h2c_byp_pkg::ADDR_W-1:0] host_rd_address,
    output logic [h2c_byp_pkg::LEN_W-1:0] host_rd_byte_count,
    // Host read data returning
    input wire logic host_data_valid,
    output logic host_data_ready,
    input wire logic [h2c_byp_pkg::DATA_W-1:0] host_data,
    // Streaming output
    output logic out_valid,
    input wire logic out_ready,
    output logic [h2c_byp_pkg::DATA_W-1:0] out_data,
    output logic out_last,
    // Status descriptor writeback and interrupt
    output logic status_wb_valid,
    input wire logic status_wb_ready,
    output logic [h2c_byp_pkg::QID_W-1:0] status_wb_queue,
    output logic host_irq,
    output logic [h2c_byp_pkg::QID_W-1:0] host_irq_queue,
    // Marker response
    output logic marker_valid,
    input wire logic marker_ready,
    output logic [h2c_byp_pkg::QID_W-1:0] marker_queue,
    // AXI4-Lite register port
    input wire logic [7:0] s_axil_awaddr,
    input wire logic s_axil_awvalid,
    output logic s_axil_awready,
    input wire logic [31:0] s_axil_wdata,
    input wire logic [3:0] s_axil_wstrb,
    input wire logic s_axil_wvalid,
    output logic s_axil_wready,
    output logic [1:0] s_axil_bresp,
    output logic s_axil_bvalid,
    input wire logic s_axil_bready,
    input wire logic [7:0] s_axil_araddr,
    input wire logic s_axil_arvalid,
    output logic s_axil_arready,
    output logic [31:0] s_axil_rdata,
    output logic [1:0] s_axil_rresp,
    output logic s_axil_rvalid,
    input wire logic s_axil_rready
);
    typedef enum logic [2:0] {
        ST_IDLE,
        ST_REQUEST,
        ST_DATA,
        ST_DRAIN,
        ST_STATUS,
        ST_MARKER
    } state_t;

    state_t state;
    h2c_byp_pkg::desc_t cur;
    h2c_byp_pkg::queue_ctx_t ctx [h2c_byp_pkg::NUM_QUEUES];
    h2c_byp_pkg::queue_ctx_t sel_ctx;
    logic engine_enable;
    logic [h2c_byp_pkg::QID_W-1:0] queue_sel;
    logic [h2c_byp_pkg::LEN_W-1:0] bytes_left;
    logic [31:0] status_count;
    logic [31:0] marker_count;
    logic [31:0] error_count;
    logic take;
    logic last_beat;
    logic fifo_in_ready;
    logic fifo_in_valid;
    h2c_byp_pkg::beat_t fifo_in;
    h2c_byp_pkg::beat_t fifo_out;
    logic wr_en;
    logic [7:0] wr_addr;
    logic [31:0] wr_data;
    logic [3:0] wr_strb;
    logic [7:0] rd_addr;
    logic [31:0] rd_data;
    logic rd_hit;
    logic wr_hit;
    logic irq_fire;

    // Register slave
    h2c_byp_axil u_axil (
        .aclk(aclk),
        .aresetn(aresetn),
        .s_axil_awaddr(s_axil_awaddr),
        .s_axil_awvalid(s_axil_awvalid),
        .s_axil_awready(s_axil_awready),
        .s_axil_wdata(s_axil_wdata),
        .s_axil_wstrb(s_axil_wstrb),
        .s_axil_wvalid(s_axil_wvalid),
        .s_axil_wready(s_axil_wready),
        .s_axil_bresp(s_axil_bresp),
        .s_axil_bvalid(s_axil_bvalid),
        .s_axil_bready(s_axil_bready),
        .s_axil_araddr(s_axil_araddr),
        .s_axil_arvalid(s_axil_arvalid),
        .s_axil_arready(s_axil_arready),
        .s_axil_rdata(s_axil_rdata),
        .s_axil_rresp(s_axil_rresp),
        .s_axil_rvalid(s_axil_rvalid),
        .s_axil_rready(s_axil_rready),
        .wr_en(wr_en),
        .wr_addr(wr_addr),
        .wr_data(wr_data),
        .wr_strb(wr_strb),
        .rd_addr(rd_addr),
        .rd_data(rd_data),
        .rd_hit(rd_hit),
        .wr_hit(wr_hit)
    );

    // Data FIFO between host reads and the stream output
    h2c_byp_fifo #(
        .WIDTH(h2c_byp_pkg::DATA_W + 1),
        .DEPTH(h2c_byp_pkg::FIFO_DEPTH)
    ) u_fifo (
        .aclk(aclk),
        .aresetn(aresetn),
        .in_valid(fifo_in_valid),
        .in_ready(fifo_in_ready),
        .in_data(fifo_in),
        .out_valid(out_valid),
        .out_ready(out_ready),
        .out_data(fifo_out)
    );
    assign out_data = fifo_out.data;
    assign out_last = fifo_out.last;

    // ready only when idle and enabled
    assign desc_ready = (state == ST_IDLE) && engine_enable;
    assign take = desc_valid && desc_ready;

    assign host_rd_valid = (state == ST_REQUEST);
    assign host_rd_address = cur.src_address;
    assign host_rd_byte_count = cur.byte_count;

    // Read data flows only while the FIFO has room, so back-pressure reaches the host
    assign last_beat = bytes_left <= h2c_byp_pkg::LEN_W'(h2c_byp_pkg::BYTES_PER_BEAT);
    assign host_data_ready = (state == ST_DATA) && fifo_in_ready;
    assign fifo_in_valid = (state == ST_DATA) && host_data_valid;
    assign fifo_in = '{data: host_data, last: last_beat && cur.packet_last};

    assign status_wb_valid = (state == ST_STATUS);
    assign status_wb_queue = cur.queue_number;
    assign marker_valid = (state == ST_MARKER);
    assign marker_queue = cur.queue_number;
    assign sel_ctx = ctx[queue_sel];
    // interrupt gated by enable and arm
    assign irq_fire = status_wb_valid && status_wb_ready && ctx[cur.queue_number].irq_enable
        && ctx[cur.queue_number].irq_armed;

    // Descriptor processing sequence
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            state <= ST_IDLE;
            cur <= '0;
            bytes_left <= 16'h0000;
        end else begin
            case (state)
                ST_IDLE: begin
                    if (take) begin
                        cur <= desc_in;
                        bytes_left <= desc_in.byte_count;
                        if (desc_in.error_flag) begin
                            state <= ST_IDLE;
                        end else if (desc_in.no_transfer) begin
                            state <= desc_in.status_irq_request ? ST_STATUS
                                : desc_in.marker_request ? ST_MARKER : ST_IDLE;
                        end else begin
                            state <= ST_REQUEST;
                        end
                    end
                end
                ST_REQUEST: begin
                    if (host_rd_ready) begin
                        // Zero-length: nothing to fetch
                        state <= (cur.byte_count == 16'h0000) ? ST_DRAIN : ST_DATA;
                    end
                end
                ST_DATA: begin
                    if (host_data_valid && fifo_in_ready) begin
                        bytes_left <= last_beat ? 16'h0000
                            : bytes_left - h2c_byp_pkg::LEN_W'(h2c_byp_pkg::BYTES_PER_BEAT);
                        if (last_beat) begin
                            state <= ST_DRAIN;
                        end
                    end
                end
                ST_DRAIN: begin
                    state <= cur.status_irq_request ? ST_STATUS
                        : cur.marker_request ? ST_MARKER : ST_IDLE;
                end
                ST_STATUS: begin
                    if (status_wb_ready) begin
                        state <= cur.marker_request ? ST_MARKER : ST_IDLE;
                    end
                end
                ST_MARKER: begin
                    if (marker_ready) begin
                        state <= ST_IDLE;
                    end
                end
                default: state <= ST_IDLE;
            endcase
        end
    end

    // Queue context store; hardware pending/error updates win over software writes
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            for (int i = 0; i < h2c_byp_pkg::NUM_QUEUES; i++) begin
                ctx[i] <= '0;
            end
        end else begin
            if (wr_en && wr_addr == h2c_byp_pkg::REG_QUEUE_CTX && wr_strb[0]) begin
                ctx[queue_sel].irq_enable <= wr_data[h2c_byp_pkg::CTX_IRQ_ENABLE];
                ctx[queue_sel].irq_armed <= wr_data[h2c_byp_pkg::CTX_IRQ_ARMED];
                if (wr_data[h2c_byp_pkg::CTX_ERROR]) begin
                    ctx[queue_sel].error <= 1'b0;
                end
            end
            if (take && !desc_in.no_transfer) begin
                ctx[desc_in.queue_number].pending <= 1'b1;
            end
            if (take && desc_in.error_flag) begin
                ctx[desc_in.queue_number].error <= 1'b1;
            end
            // pending cleared only by a writeback
            if (status_wb_valid && status_wb_ready) begin
                ctx[cur.queue_number].pending <= 1'b0;
            end
            if (irq_fire) begin
                ctx[cur.queue_number].irq_armed <= 1'b0;
            end
        end
    end

    // Interrupt pulse register
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            host_irq <= 1'b0;
            host_irq_queue <= '0;
        end else begin
            host_irq <= irq_fire;
            if (irq_fire) begin
                host_irq_queue <= cur.queue_number;
            end
        end
    end

    // Software control and event counters
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            engine_enable <= 1'b0;
            queue_sel <= '0;
            status_count <= 32'h0000_0000;
            marker_count <= 32'h0000_0000;
            error_count <= 32'h0000_0000;
        end else begin
            if (wr_en && wr_addr == h2c_byp_pkg::REG_CONTROL && wr_strb[0]) begin
                engine_enable <= wr_data[0];
            end
            if (wr_en && wr_addr == h2c_byp_pkg::REG_QUEUE_SEL) begin
                queue_sel <= wr_data[h2c_byp_pkg::QID_W-1:0];
            end
            if (status_wb_valid && status_wb_ready) begin
                status_count <= status_count + 32'h0000_0001;
            end
            if (marker_valid && marker_ready) begin
                marker_count <= marker_count + 32'h0000_0001;
            end
            if (take && desc_in.error_flag) begin
                error_count <= error_count + 32'h0000_0001;
            end
        end
    end

    // Register read mux and decode
    always_comb begin
        rd_data = 32'h0000_0000;
        rd_hit = 1'b1;
        case (rd_addr)
            h2c_byp_pkg::REG_CONTROL: rd_data = {31'h0000_0000, engine_enable};
            h2c_byp_pkg::REG_QUEUE_SEL: rd_data = {21'h00_0000, queue_sel};
            h2c_byp_pkg::REG_QUEUE_CTX: rd_data = {28'h000_0000, sel_ctx.error,
                sel_ctx.pending, sel_ctx.irq_armed, sel_ctx.irq_enable};
            h2c_byp_pkg::REG_STATUS: rd_data = {29'h0000_0000, state};
            h2c_byp_pkg::REG_STATUS_COUNT: rd_data = status_count;
            h2c_byp_pkg::REG_MARKER_COUNT: rd_data = marker_count;
            default: rd_hit = 1'b0;
        endcase
    end
    assign wr_hit = (wr_addr == h2c_byp_pkg::REG_CONTROL)
        || (wr_addr == h2c_byp_pkg::REG_QUEUE_SEL)
        || (wr_addr == h2c_byp_pkg::REG_QUEUE_CTX);
endmodule

// ### testbench/desc_source.sv
`timescale 1ns/1ps
module desc_source (
    // Clock
    input wire logic aclk,
    // Bench request
    input wire logic go,
    input wire h2c_byp_pkg::desc_t next_desc,
    // Descriptor port
    output h2c_byp_pkg::desc_t desc_in = '0,
    output logic desc_valid = 1'b0,
    input wire logic desc_ready
);
    // one offer per descriptor, held whole until taken
    // fields passed on exactly as sequenced
    always @(posedge aclk) begin
        if (go) begin
            desc_in <= next_desc;
            desc_valid <= 1'b1;
        end else if (desc_valid && desc_ready) begin
            desc_valid <= 1'b0;
            desc_in <= ~desc_in; // Stale fields must not look fresh
        end
    end
endmodule

// ### testbench/h2c_byp_assertions.sv
`timescale 1ns/1ps
module h2c_byp_checker (
    // Clock and reset
    input wire logic aclk,
    input wire logic aresetn,
    // Descriptor port
    input wire h2c_byp_pkg::desc_t desc_in,
    input wire logic desc_valid,
    input wire logic desc_ready,
    // Host read request
    input wire logic host_rd_valid,
    input wire logic [63:0] host_rd_address,
    input wire logic [15:0] host_rd_byte_count,
    // Status, interrupt and marker
    input wire logic status_wb_valid,
    input wire logic status_wb_ready,
    input wire logic [10:0] status_wb_queue,
    input wire logic host_irq,
    input wire logic [10:0] host_irq_queue,
    input wire logic marker_valid
);
    logic take, plain;
    // Descriptor taken, and whether it moves data
    assign take = desc_valid && desc_ready;
    assign plain = !desc_in.no_transfer && !desc_in.error_flag;
    default clocking @(posedge aclk); endclocking
    default disable iff (!aresetn);
    chk_ready_reset: assert property ($rose(aresetn) |-> !desc_ready)
        else $error("ready high after reset");
    chk_take_read: assert property (take && plain |=> host_rd_valid
        && host_rd_address == $past(desc_in.src_address)
        && host_rd_byte_count == $past(desc_in.byte_count))
        else $error("bad read request");
    chk_one_flight: assert property (take && plain |=> !desc_ready)
        else $error("taken while busy");
    chk_notx_quiet: assert property (take && desc_in.no_transfer
        |=> (!host_rd_valid)[*4])
        else $error("read for no-transfer");
    chk_nop_silent: assert property (take && desc_in.no_transfer
        && !desc_in.status_irq_request && !desc_in.marker_request
        |=> (!status_wb_valid && !marker_valid)[*4])
        else $error("no-op made activity");
    chk_err_dropped: assert property (take && desc_in.error_flag
        |=> (!host_rd_valid && !status_wb_valid)[*4])
        else $error("errored descriptor processed");
    chk_notx_status: assert property (take && desc_in.no_transfer
        && desc_in.status_irq_request
        |=> status_wb_valid && status_wb_queue == $past(desc_in.queue_number))
        else $error("no status for no-transfer");
    chk_wb_hold: assert property (status_wb_valid && !status_wb_ready
        |=> status_wb_valid && $stable(status_wb_queue))
        else $error("status dropped before taken");
    chk_irq_cause: assert property (host_irq |-> $past(status_wb_valid)
        && $past(status_wb_ready) && host_irq_queue == $past(status_wb_queue))
        else $error("interrupt without writeback");
endmodule

bind h2c_st_desc_bypass_in h2c_byp_checker chk_i (
    .aclk(aclk), .aresetn(aresetn), .desc_in(desc_in), .desc_valid(desc_valid),
    .desc_ready(desc_ready), .host_rd_valid(host_rd_valid), .host_rd_address(host_rd_address),
    .host_rd_byte_count(host_rd_byte_count), .status_wb_valid(status_wb_valid),
    .status_wb_ready(status_wb_ready), .status_wb_queue(status_wb_queue),
    .host_irq(host_irq), .host_irq_queue(host_irq_queue), .marker_valid(marker_valid)
);

// ### testbench/tb_top.sv
`timescale 1ns/1ps
module tb_top;
    localparam logic [63:0] SRC = 64'h0000_0012_3456_7890;
    logic aclk = 1'b0, aresetn = 1'b0, go = 1'b0, tick = 1'b0, stall = 1'b0;
    logic awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0, arvalid = 1'b0, rready = 1'b0;
    logic [7:0] awaddr = 8'h00, araddr = 8'h00;
    logic [31:0] wdata = 32'h0, out_data, rdata, last_d;
    logic [15:0] rem = 16'h0000, host_rd_byte_count;
    h2c_byp_pkg::desc_t nd = '0;
    h2c_byp_pkg::desc_t desc_in;
    logic desc_valid, desc_ready, host_rd_valid, host_data_ready, out_valid, out_last;
    logic status_wb_valid, host_irq, marker_valid, awready, wready, bvalid, arready, rvalid;
    logic [63:0] host_rd_address, rd_addr_seen;
    logic [10:0] status_wb_queue, host_irq_queue, marker_queue, wb_q, mrk_q;
    logic [1:0] bresp, rresp;
    int n_errors = 0, num_checks = 0, n_rd = 0, n_beats = 0, n_last = 0;
    int n_wb = 0, n_irq = 0, n_mrk = 0;

    initial forever #25 aclk = ~aclk;
    // Host ready every other cycle, so waits are met
    always @(posedge aclk) begin
        tick <= ~tick;
        if (host_rd_valid && tick) begin
            n_rd <= n_rd + 1;
            rd_addr_seen <= host_rd_address;
            rem <= (host_rd_byte_count + 16'h0003) >> 2;
        end else if (rem != 16'h0000 && host_data_ready) begin
            rem <= rem - 16'h0001;
        end
        if (out_valid && !stall) begin
            n_beats <= n_beats + 1;
            n_last <= n_last + int'(out_last);
            last_d <= out_data;
        end
        if (status_wb_valid && tick) begin
            n_wb <= n_wb + 1;
            wb_q <= status_wb_queue;
        end
        if (marker_valid && tick) begin
            n_mrk <= n_mrk + 1;
            mrk_q <= marker_queue;
        end
        if (host_irq) n_irq <= n_irq + 1;
    end

    h2c_st_desc_bypass_in uut (
        .aclk(aclk), .aresetn(aresetn), .desc_in(desc_in), .desc_valid(desc_valid),
        .desc_ready(desc_ready), .host_rd_valid(host_rd_valid), .host_rd_ready(tick),
        .host_rd_address(host_rd_address), .host_rd_byte_count(host_rd_byte_count),
        .host_data_valid(rem != 16'h0000), .host_data_ready(host_data_ready),
        .host_data({16'h0000, rem}), .out_valid(out_valid), .out_ready(!stall),
        .out_data(out_data), .out_last(out_last), .status_wb_valid(status_wb_valid),
        .status_wb_ready(tick), .status_wb_queue(status_wb_queue), .host_irq(host_irq),
        .host_irq_queue(host_irq_queue), .marker_valid(marker_valid), .marker_ready(tick),
        .marker_queue(marker_queue), .s_axil_awaddr(awaddr), .s_axil_awvalid(awvalid),
        .s_axil_awready(awready), .s_axil_wdata(wdata), .s_axil_wstrb(4'hf),
        .s_axil_wvalid(wvalid), .s_axil_wready(wready), .s_axil_bresp(bresp),
        .s_axil_bvalid(bvalid), .s_axil_bready(bready), .s_axil_araddr(araddr),
        .s_axil_arvalid(arvalid), .s_axil_arready(arready), .s_axil_rdata(rdata),
        .s_axil_rresp(rresp), .s_axil_rvalid(rvalid), .s_axil_rready(rready)
    );
    desc_source src (.aclk(aclk), .go(go), .next_desc(nd), .desc_in(desc_in),
        .desc_valid(desc_valid), .desc_ready(desc_ready));

    task automatic chk(input logic [63:0] seen, input logic [63:0] exp);
        num_checks++;
        if (seen !== exp) begin
            n_errors++;
            $display("MISMATCH %0t seen %0h expected %0h", $time, seen, exp);
        end
    endtask
    task automatic close_out();
        if (n_errors == 0 && num_checks > 0) begin
            $display("ALL TESTS PASSED");
        end else begin
            $display("TESTS FAILED");
        end
        $finish;
    endtask
    task automatic lim(input int i);
        if (i >= 200) begin
            chk(64'h0, 64'h1);
            close_out();
        end
    endtask
    // One register access; sampled at the falling edge to avoid races
    task automatic ax(input bit wr, input logic [7:0] a, input logic [31:0] d, input bit bad);
        int i;
        logic a_ok, w_ok, done;
        logic [31:0] got;
        logic [1:0] rs;
        awaddr <= a;
        araddr <= a;
        wdata <= d;
        awvalid <= wr;
        wvalid <= wr;
        bready <= wr;
        arvalid <= !wr;
        rready <= !wr;
        for (i = 0; i < 200; i++) begin
            @(negedge aclk);
            a_ok = wr ? awready : arready;
            w_ok = wready;
            done = wr ? bvalid : rvalid;
            rs = wr ? bresp : rresp;
            got = rdata;
            @(posedge aclk);
            if (a_ok) begin
                awvalid <= 1'b0;
                arvalid <= 1'b0;
            end
            if (w_ok) wvalid <= 1'b0;
            if (done) break;
        end
        bready <= 1'b0;
        rready <= 1'b0;
        @(posedge aclk);
        lim(i);
        chk(rs, bad ? h2c_byp_pkg::RESP_SLVERR : h2c_byp_pkg::RESP_OKAY);
        if (!wr) chk(got, bad ? 32'h0 : d);
    endtask
    // Offer one descriptor on queue 5; wait for idle and a drained output
    task automatic send(input logic [15:0] len, input logic [5:0] f);
        int i;
        nd <= {SRC, len, f, 11'h005};
        go <= 1'b1;
        @(posedge aclk);
        go <= 1'b0;
        for (i = 0; i < 200; i++) begin
            @(negedge aclk);
            if (!desc_valid && desc_ready && !out_valid) break;
        end
        lim(i);
        repeat (3) @(posedge aclk);
    endtask

    initial begin
        repeat (2) @(posedge aclk);
        aresetn <= 1'b1;
        @(posedge aclk);
        ax(0, h2c_byp_pkg::REG_CONTROL, 32'h0, 0);
        ax(0, 8'h40, 32'h0, 1);
        ax(1, 8'h40, 32'h1, 1);
        ax(1, h2c_byp_pkg::REG_CONTROL, 32'h1, 0);
        ax(1, h2c_byp_pkg::REG_QUEUE_SEL, 32'h5, 0);
        ax(1, h2c_byp_pkg::REG_QUEUE_CTX, 32'h3, 0);
        send(16'd12, 6'h20);
        send(16'd8, 6'h18);
        chk(n_beats, 5);
        chk(n_last, 1);
        chk(wb_q, 11'h005);
        chk(n_irq, 1);
        chk(rd_addr_seen, SRC);
        ax(0, h2c_byp_pkg::REG_QUEUE_CTX, 32'h1, 0);
        send(16'd4, 6'h38);
        chk(n_irq, 1);
        send(16'd4, 6'h34);
        chk(mrk_q, 11'h005);
        send(16'd8, 6'h32);
        send(16'd8, 6'h3a);
        chk(n_rd, 4);
        ax(0, h2c_byp_pkg::REG_STATUS_COUNT, 32'h3, 0);
        ax(0, h2c_byp_pkg::REG_MARKER_COUNT, 32'h1, 0);
        send(16'd8, 6'h31);
        ax(0, h2c_byp_pkg::REG_QUEUE_CTX, 32'hd, 0);
        ax(1, h2c_byp_pkg::REG_QUEUE_CTX, 32'h8, 0);
        send(16'd0, 6'h38);
        ax(0, h2c_byp_pkg::REG_QUEUE_CTX, 32'h0, 0);
        chk(n_wb, 4);
        // Output stalled so the buffer fills and refuses host data
        stall <= 1'b1;
        fork
            send(16'd160, 6'h30);
            begin
                repeat (60) @(negedge aclk);
                chk(host_data_ready, 1'b0);
                @(posedge aclk);
                stall <= 1'b0;
            end
        join
        chk(n_beats, 47);
        chk(n_last, 4);
        chk(n_rd, 6);
        chk(last_d, 32'h1);
        close_out();
    end
endmodule
